// file: logic/sps_pkg.sv
// Constants, register map and state codes for the serial-port strap loader
//////////////////////////////////////////////////////////////////////////////
package sps_pkg;
   //////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NPORT  = 2;
   localparam int NSTRAP = 6;
   localparam int AXI_AW = 8;
   //////////////////////////////////////////////////////////////////////////
   // Strap bit positions: port 0 pins then port 1 pins
   localparam int STRAP_FAN_DUTY   = 0; // Port 0 terminal-ready pin
   localparam int STRAP_VID_MODE   = 1; // Port 0 request-to-send pin
   localparam int STRAP_CFG_PORT   = 2; // Port 0 serial-out pin
   localparam int STRAP_BOOT_ROM   = 3; // Port 1 terminal-ready pin
   localparam int STRAP_FAN_METHOD = 4; // Port 1 request-to-send pin
   localparam int STRAP_FLASH_EN   = 5; // Port 1 serial-out pin
   localparam logic [NSTRAP-1:0] STRAP_DEFAULT = 6'h3F;
   //////////////////////////////////////////////////////////////////////////
   // Strap decode values
   localparam logic [7:0] CFG_PORT_HIGH = 8'h4E;
   localparam logic [7:0] CFG_PORT_LOW  = 8'h2E;
   localparam logic [6:0] DUTY_DEFAULT  = 7'h3C; // 60 percent
   localparam logic [6:0] DUTY_FULL     = 7'h64; // 100 percent
   //////////////////////////////////////////////////////////////////////////
   // Strap settle time before sampling
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS     = 100;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W      = $clog2(SETTLE_CYC + 1);
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);
   //////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [AXI_AW-1:0] ADDR_STATUS  = 8'h00;
   localparam logic [AXI_AW-1:0] ADDR_MODEM   = 8'h04;
   localparam logic [AXI_AW-1:0] ADDR_CONTROL = 8'h08;
   //////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int STAT_DONE_BIT  = 8;
   localparam int STAT_PORT_LSB  = 16;
   localparam int STAT_DUTY_LSB  = 24;
   localparam int CTL_PORT_W     = 4;  // Control bits per serial port
   localparam int CTL_TERM_READY = 0;
   localparam int CTL_REQ_SEND   = 1;
   localparam int CTL_SER_OUT    = 2;
   localparam int MDM_PORT_W     = 8;  // Modem status bits per serial port
   localparam int MDM_CARRIER    = 0;
   localparam int MDM_RING       = 1;
   localparam int MDM_SET_READY  = 2;
   localparam int MDM_CLEAR_SEND = 3;
   localparam int MDM_SER_IN     = 4;
   localparam logic [7:0] CONTROL_RESET = 8'h44; // Serial out idles high
   //////////////////////////////////////////////////////////////////////////
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   //////////////////////////////////////////////////////////////////////////
   // Loader states
   typedef enum logic [2:0] {
      SPS_ST_SETTLE = 3'b001,
      SPS_ST_SAMPLE = 3'b010,
      SPS_ST_RUN    = 3'b100
   } sps_state_t;
endpackage

// file: logic/sps_strap_capture.sv
// Strap latch: one flip-flop per strap, loaded once on the capture strobe
`timescale 1ns/10ps
module sps_strap_capture #(
   parameter int               WIDTH     = 6,
   parameter logic [WIDTH-1:0] RESET_VAL = 6'h3F
) (
   input  wire logic             i_mclk,
   input  wire logic             i_srst,
   input  wire logic             i_capture,
   input  wire logic [WIDTH-1:0] i_pins,
   output logic      [WIDTH-1:0] o_straps
);
   //////////////////////////////////////////////////////////////////////////
   // Each strap holds its defaulted value until the single capture
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge i_mclk) begin
            if (i_srst) begin
               o_straps[g] <= RESET_VAL[g];
            end else if (i_capture) begin
               o_straps[g] <= i_pins[g];
            end
         end
      end
   endgenerate
endmodule

// file: logic/sps_top.sv
// Strap loader and modem-control pins for the two serial ports, AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module sps_top
   import sps_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_srst,
   // AXI4-Lite slave
   input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_awvalid,
   output logic                   o_s_axi_awready,
   input  wire logic [31:0]       i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   input  wire logic              i_s_axi_wvalid,
   output logic                   o_s_axi_wready,
   output logic [1:0]             o_s_axi_bresp,
   output logic                   o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
   input  wire logic              i_s_axi_arvalid,
   output logic                   o_s_axi_arready,
   output logic [31:0]            o_s_axi_rdata,
   output logic [1:0]             o_s_axi_rresp,
   output logic                   o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   // Shared strap pins, one bit per serial port
   input  wire logic [NPORT-1:0]  i_terminal_ready_n,
   output logic      [NPORT-1:0]  o_terminal_ready_n,
   output logic      [NPORT-1:0]  o_terminal_ready_n_oe_n,
   output logic      [NPORT-1:0]  o_terminal_ready_n_pullup,
   input  wire logic [NPORT-1:0]  i_request_to_send_n,
   output logic      [NPORT-1:0]  o_request_to_send_n,
   output logic      [NPORT-1:0]  o_request_to_send_n_oe_n,
   output logic      [NPORT-1:0]  o_request_to_send_n_pullup,
   input  wire logic [NPORT-1:0]  i_serial_out,
   output logic      [NPORT-1:0]  o_serial_out,
   output logic      [NPORT-1:0]  o_serial_out_oe_n,
   output logic      [NPORT-1:0]  o_serial_out_pullup,
   // Modem inputs
   input  wire logic [NPORT-1:0]  i_carrier_detect_n,
   input  wire logic [NPORT-1:0]  i_ring_indicate_n,
   input  wire logic [NPORT-1:0]  i_set_ready_n,
   input  wire logic [NPORT-1:0]  i_clear_to_send_n,
   input  wire logic [NPORT-1:0]  i_serial_in,
   // Strap results
   output logic                   o_strap_done,
   output logic [6:0]             o_fan_default_duty,
   output logic                   o_voltage_id_inputs_bidir,
   output logic                   o_voltage_id_outputs_enable,
   output logic                   o_general_port_zero_enable,
   output logic [7:0]             o_config_port_addr,
   output logic                   o_boot_from_spi,
   output logic                   o_fan_drive_linear,
   output logic                   o_serial_flash_enable
);
   //////////////////////////////////////////////////////////////////////////
   // Declarations
   sps_state_t            state;
   sps_state_t            next_state;
   logic [SETTLE_W-1:0]   settle_cnt;
   logic                  capture;
   logic [NSTRAP-1:0]     strap_pins;
   logic [NSTRAP-1:0]     straps;
   logic                  running;
   logic [7:0]            control;
   logic [31:0]           modem_status;
   logic [31:0]           status_word;
   logic                  aw_held;
   logic [AXI_AW-1:0]     aw_addr;
   logic                  w_held;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  do_write;
   logic                  write_hit;
   logic [31:0]           next_rdata;
   logic [1:0]            next_rresp;

   //////////////////////////////////////////////////////////////////////////
   // Loader sequence: settle after reset, sample once, then run
   always_comb begin
      next_state = state;
      unique case (state)
         SPS_ST_SETTLE: begin
            if (settle_cnt == SETTLE_LAST) begin
               next_state = SPS_ST_SAMPLE;
            end
         end
         SPS_ST_SAMPLE: begin
            next_state = SPS_ST_RUN;
         end
         SPS_ST_RUN: begin
            next_state = SPS_ST_RUN; // Held until the next reset
         end
         default: begin
            next_state = SPS_ST_SETTLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state <= SPS_ST_SETTLE;
      end else begin
         state <= next_state;
      end
   end

   // Settle counter, only runs while settling
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         settle_cnt <= '0;
      end else if (state == SPS_ST_SETTLE) begin
         settle_cnt <= settle_cnt + SETTLE_W'(1);
      end
   end

   assign capture = (state == SPS_ST_SAMPLE);
   assign running = (state == SPS_ST_RUN);

   //////////////////////////////////////////////////////////////////////////
   // Pin levels as seen by the strap latch
   assign strap_pins = {i_serial_out[1], i_request_to_send_n[1], i_terminal_ready_n[1],
                        i_serial_out[0], i_request_to_send_n[0], i_terminal_ready_n[0]};

   sps_strap_capture #(
      .WIDTH     (NSTRAP),
      .RESET_VAL (STRAP_DEFAULT)
   ) sps_strap_capture_inst (
      .i_mclk    (i_mclk),
      .i_srst    (i_srst),
      .i_capture (capture),
      .i_pins    (strap_pins),
      .o_straps  (straps)
   );

   //////////////////////////////////////////////////////////////////////////
   // Strap decode, registered so the outputs come from flip-flops
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_strap_done <= 1'b0;
      end else begin
         o_strap_done <= running;
      end
   end

   // Fan defaults
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_fan_default_duty <= DUTY_DEFAULT;
         o_fan_drive_linear <= 1'b0;
      end else begin
         o_fan_default_duty <= straps[STRAP_FAN_DUTY] ? DUTY_DEFAULT : DUTY_FULL;
         o_fan_drive_linear <= ~straps[STRAP_FAN_METHOD];
      end
   end

   // Voltage-ID pin use
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_voltage_id_inputs_bidir   <= 1'b0;
         o_voltage_id_outputs_enable <= 1'b1;
         o_general_port_zero_enable  <= 1'b0;
      end else begin
         o_voltage_id_inputs_bidir   <= ~straps[STRAP_VID_MODE];
         o_voltage_id_outputs_enable <= straps[STRAP_VID_MODE];
         o_general_port_zero_enable  <= ~straps[STRAP_VID_MODE];
      end
   end

   // Configuration port, boot ROM and serial flash
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_config_port_addr    <= CFG_PORT_HIGH;
         o_boot_from_spi       <= 1'b0;
         o_serial_flash_enable <= 1'b0;
      end else begin
         o_config_port_addr    <= straps[STRAP_CFG_PORT] ? CFG_PORT_HIGH : CFG_PORT_LOW;
         o_boot_from_spi       <= ~straps[STRAP_BOOT_ROM];
         o_serial_flash_enable <= ~straps[STRAP_FLASH_EN];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Shared pins: pull-up and released while strapping, driven afterwards
   genvar p;
   generate
      for (p = 0; p < NPORT; p++) begin : g_port
         always_ff @(posedge i_mclk) begin
            if (i_srst) begin
               o_terminal_ready_n_oe_n[p]    <= 1'b1;
               o_request_to_send_n_oe_n[p]   <= 1'b1;
               o_serial_out_oe_n[p]          <= 1'b1;
               o_terminal_ready_n_pullup[p]  <= 1'b1;
               o_request_to_send_n_pullup[p] <= 1'b1;
               o_serial_out_pullup[p]        <= 1'b1;
            end else begin
               o_terminal_ready_n_oe_n[p]    <= ~running;
               o_request_to_send_n_oe_n[p]   <= ~running;
               o_serial_out_oe_n[p]          <= ~running;
               o_terminal_ready_n_pullup[p]  <= ~running;
               o_request_to_send_n_pullup[p] <= ~running;
               o_serial_out_pullup[p]        <= ~running;
            end
         end

         // Pin levels; a set control bit drives terminal-ready and request-to-send low, serial-out high
         always_ff @(posedge i_mclk) begin
            if (i_srst) begin
               o_terminal_ready_n[p]  <= 1'b1;
               o_request_to_send_n[p] <= 1'b1;
               o_serial_out[p]        <= 1'b1;
            end else begin
               o_terminal_ready_n[p]  <= ~control[p*CTL_PORT_W+CTL_TERM_READY];
               o_request_to_send_n[p] <= ~control[p*CTL_PORT_W+CTL_REQ_SEND];
               o_serial_out[p]        <= control[p*CTL_PORT_W+CTL_SER_OUT];
            end
         end

         // Modem status shown as asserted-high bits
         assign modem_status[p*MDM_PORT_W+MDM_CARRIER]    = ~i_carrier_detect_n[p];
         assign modem_status[p*MDM_PORT_W+MDM_RING]       = ~i_ring_indicate_n[p];
         assign modem_status[p*MDM_PORT_W+MDM_SET_READY]  = ~i_set_ready_n[p];
         assign modem_status[p*MDM_PORT_W+MDM_CLEAR_SEND] = ~i_clear_to_send_n[p];
         assign modem_status[p*MDM_PORT_W+MDM_SER_IN]     = i_serial_in[p];
         assign modem_status[p*MDM_PORT_W+7:p*MDM_PORT_W+5] = 3'h0;
      end
   endgenerate

   assign modem_status[31:NPORT*MDM_PORT_W] = '0;

   // Status word: raw straps, done flag, config port and fan duty
   assign status_word = {1'b0, o_fan_default_duty, o_config_port_addr,
                         7'h00, o_strap_done, 2'h0, straps};

   //////////////////////////////////////////////////////////////////////////
   // AXI write: address and data taken in either order
   assign o_s_axi_awready = ~aw_held;
   assign o_s_axi_wready  = ~w_held;
   assign do_write        = aw_held & w_held & ~o_s_axi_bvalid;
   assign write_hit       = (aw_addr[AXI_AW-1:2] == ADDR_CONTROL[AXI_AW-1:2]);

   // Write address holding register
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (i_s_axi_awvalid && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr <= i_s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // Write data holding register
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (i_s_axi_wvalid && !w_held) begin
         w_held <= 1'b1;
         w_data <= i_s_axi_wdata;
         w_strb <= i_s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp  <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   // Control register, low byte lane only
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         control <= CONTROL_RESET;
      end else if (do_write && write_hit && w_strb[0]) begin
         control <= w_data[7:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // AXI read: one outstanding read, data registered
   assign o_s_axi_arready = ~o_s_axi_rvalid;

   // Read decode
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      if (i_s_axi_araddr[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2]) begin
         next_rdata = status_word;
      end else if (i_s_axi_araddr[AXI_AW-1:2] == ADDR_MODEM[AXI_AW-1:2]) begin
         next_rdata = modem_status;
      end else if (i_s_axi_araddr[AXI_AW-1:2] == ADDR_CONTROL[AXI_AW-1:2]) begin
         next_rdata = {24'h00_0000, control};
      end else begin
         next_rresp = RESP_SLVERR;
      end
   end

   // Read response
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata  <= 32'h0000_0000;
         o_s_axi_rresp  <= RESP_OKAY;
      end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata  <= next_rdata;
         o_s_axi_rresp  <= next_rresp;
      end else if (i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// file: dv/sps_top_asserts.sv
// Checker for strap capture timing, strap decode and pin release
`timescale 1ns/10ps
module sps_top_asserts
   import sps_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_srst,
   input  wire logic [NPORT-1:0] i_terminal_ready_n,
   input  wire logic [NPORT-1:0] i_request_to_send_n,
   input  wire logic [NPORT-1:0] i_serial_out,
   input  wire logic [NPORT-1:0] o_terminal_ready_n_oe_n,
   input  wire logic [NPORT-1:0] o_terminal_ready_n_pullup,
   input  wire logic [NPORT-1:0] o_request_to_send_n_oe_n,
   input  wire logic [NPORT-1:0] o_request_to_send_n_pullup,
   input  wire logic [NPORT-1:0] o_serial_out_oe_n,
   input  wire logic [NPORT-1:0] o_serial_out_pullup,
   input  wire logic             o_strap_done,
   input  wire logic [6:0]       o_fan_default_duty,
   input  wire logic             o_voltage_id_inputs_bidir,
   input  wire logic             o_voltage_id_outputs_enable,
   input  wire logic             o_general_port_zero_enable,
   input  wire logic [7:0]       o_config_port_addr,
   input  wire logic             o_boot_from_spi,
   input  wire logic             o_fan_drive_linear,
   input  wire logic             o_serial_flash_enable
);
   logic [3:0] cnt;
   logic [5:0] cap;
   logic [5:0] oe_all;
   logic [5:0] pu_all;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   assign oe_all = {o_serial_out_oe_n, o_request_to_send_n_oe_n, o_terminal_ready_n_oe_n};
   assign pu_all = {o_serial_out_pullup, o_request_to_send_n_pullup, o_terminal_ready_n_pullup};
   ////////////////////////////////////////////////////////////////////////////
   // Edges since reset release, saturating
   always_ff @(posedge i_mclk) begin
      if (i_srst)
         cnt <= 4'h0;
      else if (cnt != 4'hF)
         cnt <= cnt + 4'h1;
   end
   // Pin levels at the capture edge, in strap order
   always_ff @(posedge i_mclk) begin
      if (cnt == 4'hA)
         cap <= {i_serial_out[1], i_request_to_send_n[1], i_terminal_ready_n[1],
                 i_serial_out[0], i_request_to_send_n[0], i_terminal_ready_n[0]};
   end
   ////////////////////////////////////////////////////////////////////////////
   a_strap_pullup: assert property (!o_strap_done |-> (&pu_all) && (&oe_all))
      else $error("strap pin not released while strapping");
   a_pin_release: assert property (o_strap_done |-> pu_all == 6'h00 && oe_all == 6'h00)
      else $error("strap pin not driven after strapping");
   a_done_time: assert property ($rose(o_strap_done) |-> cnt == 4'hC)
      else $error("strap done at wrong edge");
   a_done_hold: assert property (o_strap_done |=> o_strap_done)
      else $error("strap done dropped");
   a_duty_map: assert property (o_strap_done |-> o_fan_default_duty == (cap[0] ? DUTY_DEFAULT : DUTY_FULL))
      else $error("fan duty decode wrong");
   a_vid_high: assert property (o_strap_done && cap[1] |->
      o_voltage_id_outputs_enable && !o_voltage_id_inputs_bidir && !o_general_port_zero_enable)
      else $error("voltage id high decode wrong");
   a_vid_low: assert property (o_strap_done && !cap[1] |->
      !o_voltage_id_outputs_enable && o_voltage_id_inputs_bidir && o_general_port_zero_enable)
      else $error("voltage id low decode wrong");
   a_cfg_map: assert property (o_strap_done |-> o_config_port_addr == (cap[2] ? CFG_PORT_HIGH : CFG_PORT_LOW))
      else $error("config port decode wrong");
   a_misc_map: assert property (o_strap_done |->
      {o_serial_flash_enable, o_fan_drive_linear, o_boot_from_spi} == ~cap[5:3])
      else $error("boot, fan method or flash decode wrong");
   a_strap_stable: assert property (o_strap_done |=> $stable({o_fan_default_duty, o_config_port_addr,
      o_voltage_id_outputs_enable, o_boot_from_spi, o_fan_drive_linear, o_serial_flash_enable}))
      else $error("strap result changed");
   c_done: cover property ($rose(o_strap_done));
   c_vid_low: cover property (o_strap_done && !cap[1]);
   c_all_default: cover property (o_strap_done && cap == 6'h3F);
endmodule
bind sps_top sps_top_asserts sps_top_asserts_inst (.i_mclk, .i_srst, .i_terminal_ready_n,
   .i_request_to_send_n, .i_serial_out, .o_terminal_ready_n_oe_n, .o_terminal_ready_n_pullup,
   .o_request_to_send_n_oe_n, .o_request_to_send_n_pullup, .o_serial_out_oe_n, .o_serial_out_pullup,
   .o_strap_done, .o_fan_default_duty, .o_voltage_id_inputs_bidir, .o_voltage_id_outputs_enable,
   .o_general_port_zero_enable, .o_config_port_addr, .o_boot_from_spi, .o_fan_drive_linear,
   .o_serial_flash_enable);

// file: dv/sps_board_model.sv
// Board model: strap resistors on the shared pins and the attached modem
`timescale 1ns/10ps
module sps_board_model (
   input  wire logic [5:0] i_drv,
   input  wire logic [5:0] i_oe_n,
   input  wire logic [5:0] i_pullup,
   input  wire logic [5:0] i_pulldown,
   output logic      [5:0] o_level
);
   // Pin level: device drive, else strong pull-down, else pull-up, else drifting
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         if (!i_oe_n[k])
            o_level[k] = i_drv[k];
         else if (i_pulldown[k])
            o_level[k] = 1'b0;
         else if (i_pullup[k])
            o_level[k] = 1'b1;
         else
            o_level[k] = ~i_drv[k];
      end
   end
endmodule
// Modem side: status lines asserted by pulling them low
module sps_modem_model (
   input  wire logic [7:0] i_assert,
   output logic      [7:0] o_modem_n
);
   assign o_modem_n = ~i_assert;
endmodule

// file: dv/sps_top_test.sv
// Self-checking bench: strap capture, modem inputs and modem-control pins
`timescale 1ns/10ps
module sps_top_test;
   import sps_pkg::*;
   logic        i_mclk = 0;
   logic        i_srst = 1;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [5:0]  pd = 0;
   logic [9:0]  mv = 0;
   wire logic   awready, wready, bvalid, arready, rvalid, done, vbi, voe, gpz, spi, lin, fen;
   wire logic [1:0]  bresp, rresp, tro, rqo, soo, troe, rqoe, sooe, trpu, rqpu, sopu;
   wire logic [31:0] rdata;
   wire logic [6:0]  duty;
   wire logic [7:0]  cfg, mdmn;
   wire logic [5:0]  lvl, drv, oe, pu;
   int          n_fail = 0, compares = 0, cyc = 0;
   assign drv = {soo[1], rqo[1], tro[1], soo[0], rqo[0], tro[0]};
   assign oe = {sooe[1], rqoe[1], troe[1], sooe[0], rqoe[0], troe[0]};
   assign pu = {sopu[1], rqpu[1], trpu[1], sopu[0], rqpu[0], trpu[0]};
   ////////////////////////////////////////////////////////////////////////////
   sps_top sps_top_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .i_terminal_ready_n({lvl[3], lvl[0]}), .o_terminal_ready_n(tro),
      .o_terminal_ready_n_oe_n(troe), .o_terminal_ready_n_pullup(trpu),
      .i_request_to_send_n({lvl[4], lvl[1]}), .o_request_to_send_n(rqo), .o_request_to_send_n_oe_n(rqoe),
      .o_request_to_send_n_pullup(rqpu), .i_serial_out({lvl[5], lvl[2]}), .o_serial_out(soo),
      .o_serial_out_oe_n(sooe), .o_serial_out_pullup(sopu), .i_carrier_detect_n(mdmn[1:0]),
      .i_ring_indicate_n(mdmn[3:2]), .i_set_ready_n(mdmn[5:4]), .i_clear_to_send_n(mdmn[7:6]),
      .i_serial_in(mv[9:8]), .o_strap_done(done), .o_fan_default_duty(duty),
      .o_voltage_id_inputs_bidir(vbi), .o_voltage_id_outputs_enable(voe), .o_general_port_zero_enable(gpz),
      .o_config_port_addr(cfg), .o_boot_from_spi(spi), .o_fan_drive_linear(lin),
      .o_serial_flash_enable(fen));
   sps_board_model sps_board_model_inst (.i_drv(drv), .i_oe_n(oe), .i_pullup(pu), .i_pulldown(pd),
      .o_level(lvl));
   sps_modem_model sps_modem_model_inst (.i_assert(mv[7:0]), .o_modem_n(mdmn));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   // Bus write: both channels offered, held until taken, then response
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ha, hw, hb;
      logic [1:0] r;
      @(posedge i_mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      hb = 0;
      while (!hb) begin
         @(negedge i_mclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         r = bresp;
         @(posedge i_mclk);
         if (ha)
            awvalid <= 0;
         if (hw)
            wvalid <= 0;
      end
      bready <= 0;
      chk(r, er);
   endtask
   // Bus read: address held until taken, data taken with rvalid
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ha, hr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge i_mclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      hr = 0;
      while (!hr) begin
         @(negedge i_mclk);
         ha = arvalid & arready;
         hr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge i_mclk);
         if (ha)
            arvalid <= 0;
      end
      rready <= 0;
      chk(d, ed);
      chk(r, er);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Reset with a pull-down pattern, then check capture and decode
   task automatic boot(input logic [5:0] p);
      logic [5:0] s;
      logic [6:0] ed;
      logic [7:0] ec;
      int n;
      @(posedge i_mclk);
      pd <= p;
      i_srst <= 1;
      repeat (20) @(posedge i_mclk);
      i_srst <= 0;
      s = ~p;
      ed = s[0] ? 7'h3C : 7'h64;
      ec = s[2] ? 8'h4E : 8'h2E;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge i_mclk);
         n++;
      end
      chk(n, 13);
      chk(duty, ed);
      chk({vbi, voe, gpz}, s[1] ? 3'b010 : 3'b101);
      chk(cfg, ec);
      chk({fen, lin, spi}, {~s[5:3]});
      chk({oe, pu}, 12'h000);
      chk(lvl, 6'h3F);
      pd <= ~p;
      axr(ADDR_STATUS, {1'b0, ed, ec, 7'h00, 1'b1, 2'h0, s}, RESP_OKAY);
   endtask
   // Control writes drive terminal-ready and request-to-send low when asserted
   task automatic ctl();
      axw(ADDR_CONTROL, 32'h33, RESP_OKAY);
      @(negedge i_mclk);
      chk({tro, rqo, soo, lvl}, 12'h000);
      axr(ADDR_CONTROL, 32'h33, RESP_OKAY);
      axw(ADDR_CONTROL, 32'h12, RESP_OKAY);
      @(negedge i_mclk);
      chk({tro, rqo, soo}, 6'b01_10_00);
      axw(ADDR_STATUS, 32'h0, RESP_SLVERR);
      axr(8'h0C, 32'h0, RESP_SLVERR);
   endtask
   // Modem asserts a pattern; status bits read back as asserted
   task automatic modem(input logic [9:0] v);
      logic [31:0] e;
      @(posedge i_mclk);
      mv <= v;
      e = 0;
      for (int p = 0; p < 2; p++)
         e[8*p +: 5] = {v[8+p], v[6+p], v[4+p], v[2+p], v[p]};
      axr(ADDR_MODEM, e, RESP_OKAY);
   endtask
   initial begin
      boot(6'h00);
      boot(6'h2A);
      ctl();
      modem(10'h265);
      modem(10'h19A);
      boot(6'h15);
      conclude();
   end
endmodule
